// [tick_timer_pkg.sv]
`default_nettype none
package tick_timer_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] ADDR_OPTION = 8'h00;
  localparam logic [7:0] ADDR_TICK = 8'h04;
  localparam logic [7:0] ADDR_IRQ = 8'h08;

  // ==========================================================
  // field positions
  localparam int OPT_CS_BIT = 5;
  localparam int OPT_SE_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  localparam int OPT_PS_LSB = 0;
  localparam int IRQ_EN_BIT = 5;
  localparam int IRQ_FLAG_BIT = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] OPTION_RESET = 8'h08;
  localparam logic [7:0] TICK_RESET = 8'h00;
  localparam logic IRQ_EN_RESET = 1'b0;

  // ==========================================================
  // timing
  localparam int TOSC_NS = 4;
  localparam int PHASES_PER_CYCLE = 4;
  localparam logic [1:0] Q2_PHASE = 2'h1;
  localparam logic [1:0] Q4_PHASE = 2'h3;
  localparam logic [1:0] WRITE_INHIBIT = 2'h2;

  // ==========================================================
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic clock_source_select;
    logic source_edge_select;
    logic prescaler_assign;
    logic [2:0] prescale_sel;
  } option_t;

endpackage
`default_nettype wire

// [tick_timer.sv]
// Overview of operation
// - 8-bit tick count; rolling from ff to 00 sets the overflow flag.
// - with internal source and no prescaler, count once per instruction cycle.
// - a tick count write blocks incrementing for the next two instruction cycles.
// - with external source selected, count on the chosen external edge.
// - edge select clear counts rising edges, set counts falling edges.
// - one prescaler shared; assign bit clear serves counter, set serves watchdog.
// - the prescaler count is never readable or writable by software.
// - prescaler on the counter divides by powers of two from 2 to 256.
// - overflow interrupt masked while the enable bit is clear.
// - overflow flag stays set until software clears it.
// - counter and prescaler halt during sleep.
// - prescaler output is sampled at phases Q2 and Q4.
// - without prescaler the external input is the prescaler output directly.
// - with prescaler, external edges ripple through divider before sampling.
// - a sampled external edge increments the count one cycle later.
`timescale 1ns/1ps
`default_nettype none

module tick_timer #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic arst_n,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // pins and system
  input wire logic ext_count_input,
  input wire logic sleep,
  input wire logic wdt_source_tick,
  output logic wdt_tick,
  output logic irq
);

  // ==========================================================
  // register state
  tick_timer_pkg::option_t option;
  logic [7:0] tick_count;
  logic overflow_flag;
  logic overflow_irq_enable;

  // ==========================================================
  // address decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] offs);
    hit = (a[ADDR_W-1:2] == offs[ADDR_W-1:2]);
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    mapped = hit(a, tick_timer_pkg::ADDR_OPTION) || hit(a, tick_timer_pkg::ADDR_TICK) ||
             hit(a, tick_timer_pkg::ADDR_IRQ);
  endfunction

  // ==========================================================
  // write channel
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic aw_now;
  logic w_now;
  logic wr_fire;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign aw_now = aw_held || (awvalid && awready);
  assign w_now = w_held || (wvalid && wready);
  assign wr_fire = aw_now && w_now && !bvalid;
  assign wr_addr = aw_held ? aw_addr_q : awaddr;
  assign wr_data = w_held ? w_data_q : wdata;
  assign wr_strb = w_held ? w_strb_q : wstrb;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held <= 1'b0;
      aw_addr_q <= '0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr_q <= awaddr;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      w_held <= 1'b0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid <= 1'b0;
      bresp <= tick_timer_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= mapped(wr_addr) ? tick_timer_pkg::RESP_OKAY : tick_timer_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  logic opt_wr;
  logic tick_wr;
  logic irq_wr;
  assign opt_wr = wr_fire && wr_strb[0] && hit(wr_addr, tick_timer_pkg::ADDR_OPTION);
  assign tick_wr = wr_fire && wr_strb[0] && hit(wr_addr, tick_timer_pkg::ADDR_TICK);
  assign irq_wr = wr_fire && wr_strb[0] && hit(wr_addr, tick_timer_pkg::ADDR_IRQ);

  // ==========================================================
  // read channel, prescaler count has no address
  logic [31:0] rd_word;
  assign arready = !rvalid;

  always_comb begin
    rd_word = 32'h0;
    if (hit(araddr, tick_timer_pkg::ADDR_OPTION)) begin
      rd_word[5:0] = option;
    end else if (hit(araddr, tick_timer_pkg::ADDR_TICK)) begin
      rd_word[7:0] = tick_count;
    end else if (hit(araddr, tick_timer_pkg::ADDR_IRQ)) begin
      rd_word[tick_timer_pkg::IRQ_EN_BIT] = overflow_irq_enable;
      rd_word[tick_timer_pkg::IRQ_FLAG_BIT] = overflow_flag;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= tick_timer_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_word;
      rresp <= mapped(araddr) ? tick_timer_pkg::RESP_OKAY : tick_timer_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // option and irq control registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      option <= tick_timer_pkg::OPTION_RESET[5:0];
    end else if (opt_wr) begin
      option <= wr_data[5:0];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_irq_enable <= tick_timer_pkg::IRQ_EN_RESET;
    end else if (irq_wr) begin
      overflow_irq_enable <= wr_data[tick_timer_pkg::IRQ_EN_BIT];
    end
  end

  // ==========================================================
  // instruction cycle phases
  logic [1:0] phase;
  logic q2;
  logic q4;
  assign q2 = (phase == tick_timer_pkg::Q2_PHASE);
  assign q4 = (phase == tick_timer_pkg::Q4_PHASE);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      phase <= 2'h0;
    end else begin
      phase <= phase + 2'h1;
    end
  end

  // ==========================================================
  // external edge and shared prescaler
  logic ext_level;
  logic ext_prev;
  logic ext_edge;
  logic pre_event;
  logic [7:0] pre_cnt;
  logic pre_bit;
  logic pre_prev;
  logic pre_rise;
  logic pre_out;

  assign ext_level = ext_count_input ^ option.source_edge_select;
  assign ext_edge = ext_level && !ext_prev;
  assign pre_event = option.prescaler_assign ? wdt_source_tick :
                     (option.clock_source_select ? ext_edge : q4);
  assign pre_bit = pre_cnt[option.prescale_sel];
  assign pre_rise = pre_bit && !pre_prev;
  assign pre_out = option.prescaler_assign ? ext_level : pre_bit;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_prev <= 1'b0;
      pre_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
      pre_prev <= pre_bit;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_cnt <= 8'h00;
    end else if (pre_event && !sleep) begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wdt_tick <= 1'b0;
    end else begin
      wdt_tick <= option.prescaler_assign ? pre_rise : wdt_source_tick;
    end
  end

  // ==========================================================
  // phase sampling and increment delay
  logic samp;
  logic samp_prev;
  logic sync_edge;
  logic ext_pending;
  assign sync_edge = samp && !samp_prev;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      samp <= 1'b0;
    end else if (q2 || q4) begin
      samp <= pre_out;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      samp_prev <= 1'b0;
      ext_pending <= 1'b0;
    end else begin
      samp_prev <= samp;
      ext_pending <= sync_edge;
    end
  end

  // ==========================================================
  // tick count, write inhibit, overflow
  logic [1:0] inhibit;
  logic src_inc;
  logic inc_req;
  logic ovf_set;

  assign src_inc = option.clock_source_select ? ext_pending :
                   (option.prescaler_assign ? q4 : pre_rise);
  assign inc_req = src_inc && !sleep && (inhibit == 2'h0);
  assign ovf_set = inc_req && !tick_wr && (tick_count == 8'hff);

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      inhibit <= 2'h0;
    end else if (tick_wr) begin
      inhibit <= tick_timer_pkg::WRITE_INHIBIT;
    end else if (q4 && inhibit != 2'h0) begin
      inhibit <= inhibit - 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_count <= tick_timer_pkg::TICK_RESET;
    end else if (tick_wr) begin
      tick_count <= wr_data[7:0];
    end else if (inc_req) begin
      tick_count <= tick_count + 8'h01;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag <= 1'b0;
    end else if (ovf_set) begin
      overflow_flag <= 1'b1;
    end else if (irq_wr && wr_data[tick_timer_pkg::IRQ_FLAG_BIT]) begin
      overflow_flag <= 1'b0;
    end
  end

  assign irq = overflow_flag && overflow_irq_enable;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!arst_n);

  a_overflow_sets: assert property (ovf_set |=> overflow_flag && tick_count == 8'h00)
    else $error("overflow did not set flag");
  a_timer_rate: assert property (!option.clock_source_select && option.prescaler_assign &&
      !sleep && inhibit == 2'h0 && q4 && !tick_wr |=> tick_count == $past(tick_count) + 8'h01)
    else $error("timer mode missed an increment");
  a_inhibit_load: assert property (tick_wr |=>
      inhibit == tick_timer_pkg::WRITE_INHIBIT && tick_count == $past(wr_data[7:0]))
    else $error("write did not start inhibit");
  a_inhibit_hold: assert property (inhibit != 2'h0 && !tick_wr |=> $stable(tick_count))
    else $error("count moved during inhibit");
  a_ext_count: assert property (option.clock_source_select && ext_pending &&
      inhibit == 2'h0 && !sleep && !tick_wr |=> tick_count == $past(tick_count) + 8'h01)
    else $error("external edge not counted");
  a_edge_polarity: assert property (ext_edge && $stable(option.source_edge_select) |->
      ext_count_input != option.source_edge_select &&
      $past(ext_count_input) == option.source_edge_select)
    else $error("wrong edge counted");
  a_wdt_bypass: assert property (option.prescaler_assign && !option.clock_source_select &&
      !sleep && q4 && inhibit == 2'h0 && !tick_wr |=> tick_count != $past(tick_count))
    else $error("counter lost its cycle source");
  a_prescale_step: assert property (!option.prescaler_assign &&
      !option.clock_source_select && !sleep && q4 |=> pre_cnt == $past(pre_cnt) + 8'h01)
    else $error("prescaler did not step");
  a_irq_masked: assert property (!overflow_irq_enable |-> !irq)
    else $error("masked interrupt asserted");
  a_flag_sticky: assert property (overflow_flag &&
      !(irq_wr && wr_data[tick_timer_pkg::IRQ_FLAG_BIT]) |=> overflow_flag)
    else $error("flag dropped without clear");
  a_flag_clear: assert property (irq_wr && wr_data[tick_timer_pkg::IRQ_FLAG_BIT] &&
      !ovf_set |=> !overflow_flag)
    else $error("flag not cleared by write");
  a_sleep_halt: assert property (sleep && !tick_wr |=> $stable(tick_count) && $stable(pre_cnt))
    else $error("count moved in sleep");
  a_sample_phase: assert property (!(q2 || q4) |=> $stable(samp))
    else $error("sampled outside q2 q4");
  a_edge_delay: assert property (sync_edge |=> ext_pending ##1 !ext_pending)
    else $error("edge delay wrong");
  a_ext_prescale: assert property (!option.prescaler_assign && option.clock_source_select &&
      ext_edge && !sleep |=> pre_cnt == $past(pre_cnt) + 8'h01)
    else $error("divider missed an external edge");
  a_bypass_path: assert property (option.prescaler_assign && (q2 || q4) |=>
      samp == $past(ext_level))
    else $error("bypass sample wrong");
  a_wdt_direct: assert property (!option.prescaler_assign |=>
      wdt_tick == $past(wdt_source_tick))
    else $error("watchdog tick not passed through");

  c_overflow: cover property (ovf_set);
  c_ext_inc: cover property (option.clock_source_select && inc_req);
  c_irq: cover property ($rose(irq));
  c_write_then_count: cover property (tick_wr ##[1:20] inc_req);
  c_divided_ext: cover property (!option.prescaler_assign && option.clock_source_select && inc_req);

endmodule // tick_timer

`default_nettype wire

// [tick_timer_pkg_unused_guard.sv]
`timescale 1ns/1ps

// [ext_pulse_src.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// external count source: exact toggle bursts, level held between
module ext_pulse_src (
  // clock
  input wire logic ref_clk,
  // burst control
  input wire logic go,
  input wire logic [7:0] toggles,
  input wire logic [7:0] half,
  // count pin
  output logic ext_count_input
);
  logic [7:0] left = 8'h00;
  logic [7:0] cnt = 8'h00;
  initial ext_count_input = 1'b0;
  always @(posedge ref_clk) begin
    if (go) begin
      left <= toggles;
      cnt <= 8'h00;
    end else if (left != 8'h00) begin
      if (cnt == half - 8'h01) begin
        ext_count_input <= ~ext_count_input;
        left <= left - 8'h01;
        cnt <= 8'h00;
      end else begin
        cnt <= cnt + 8'h01;
      end
    end
  end
endmodule // ext_pulse_src
`default_nettype wire

// [tick_timer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// bench
module tick_timer_tb;
  localparam logic [7:0] A_OPT = tick_timer_pkg::ADDR_OPTION;
  localparam logic [7:0] A_TICK = tick_timer_pkg::ADDR_TICK;
  localparam logic [7:0] A_IRQ = tick_timer_pkg::ADDR_IRQ;
  localparam logic [1:0] OK = tick_timer_pkg::RESP_OKAY;
  logic ref_clk = 1'b0, arst_n = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, sleep = 1'b0, wdt_source_tick = 1'b0, go = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, toggles = 8'h00;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = 32'h0, v, u;
  logic awready, wready, bvalid, arready, rvalid, ext_count_input, wdt_tick, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int n_fail = 0, n_compared = 0, cyc = 0, t_wr = 0, t_ar = 0, n_wdt = 0, t0, s;

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  always @(posedge ref_clk) if (wdt_tick === 1'b1) n_wdt <= n_wdt + 1;

  tick_timer tick_timer_i (.ref_clk(ref_clk), .arst_n(arst_n), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .ext_count_input(ext_count_input), .sleep(sleep),
    .wdt_source_tick(wdt_source_tick), .wdt_tick(wdt_tick), .irq(irq));
  ext_pulse_src ext_pulse_src_i (.ref_clk(ref_clk), .go(go), .toggles(toggles),
    .half(8'h04), .ext_count_input(ext_count_input));

  // ==========================================================
  // checks and bus tasks
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_fail++;
      $display("Error: %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input logic [31:0] g, input int lo, input int hi);
    n_compared++;
    if ($isunknown(g) || int'(g) < lo || int'(g) > hi) begin
      n_fail++;
      $display("Error: %s expected %0d to %0d seen %h", nm, lo, hi, g);
    end
  endtask
  task automatic ran_out(input int k, input string nm);
    if (k >= 50) begin
      n_fail++;
      $display("Error: %s expected answer seen none", nm);
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa, pw, ta, tw, got;
    logic [1:0] r;
    int k;
    awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d; bready <= 1'b1;
    pa = 1'b1; pw = 1'b1; got = 1'b0; k = 0;
    while (!got && k < 50) begin
      @(negedge ref_clk);
      ta = pa && awready; tw = pw && wready; got = !pa && !pw && bvalid; r = bresp;
      @(posedge ref_clk);
      if (ta) begin awvalid <= 1'b0; pa = 1'b0; t_wr = cyc; end
      if (tw) begin wvalid <= 1'b0; pw = 1'b0; t_wr = cyc; end
      k++;
    end
    bready <= 1'b0;
    @(posedge ref_clk);
    ran_out(got ? 0 : k, "bvalid");
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    logic pa, ta, got;
    logic [1:0] r;
    int k;
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    pa = 1'b1; got = 1'b0; k = 0;
    while (!got && k < 50) begin
      @(negedge ref_clk);
      ta = pa && arready; got = !pa && rvalid; d = rdata; r = rresp;
      @(posedge ref_clk);
      if (ta) begin arvalid <= 1'b0; pa = 1'b0; t_ar = cyc; end
      k++;
    end
    rready <= 1'b0;
    @(posedge ref_clk);
    ran_out(got ? 0 : k, "rvalid");
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask
  // ticks between two reads w cycles apart, p cycles per tick
  task automatic rate(input int p, input int w, input string nm);
    logic [31:0] a, b;
    rd(A_TICK, a, OK); t0 = t_ar;
    repeat (w) @(posedge ref_clk);
    rd(A_TICK, b, OK); s = t_ar - t0;
    rng(nm, (b - a) & 32'hff, s / p, (s + p - 1) / p);
  endtask
  task automatic burst(input logic [7:0] n);
    toggles <= n; go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    repeat (8 * n + 16) @(posedge ref_clk);
  endtask

  // ==========================================================
  // tests
  initial begin
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    @(posedge ref_clk);
    rd(A_OPT, v, OK); chk("option reset", 32'h08, v);
    rd(A_IRQ, v, OK); chk("irq reset", 32'h0, v);
    rd(8'h0c, v, tick_timer_pkg::RESP_SLVERR); chk("unmapped", 32'h0, v);
    wr(8'h0c, 32'hff, tick_timer_pkg::RESP_SLVERR);
    $display("test reset done");
    rate(4, 40, "timer rate");
    wr(A_TICK, 32'h10, OK); t0 = t_wr;
    repeat (40) @(posedge ref_clk);
    rd(A_TICK, v, OK); s = t_ar - t0;
    rng("tick after write", (v - 32'h10) & 32'hff, (s - 1) / 4 - 2, (s + 2) / 4 - 2);
    $display("test timer done");
    wr(A_IRQ, 32'h04, OK);
    wr(A_TICK, 32'hfe, OK);
    repeat (24) @(posedge ref_clk);
    @(negedge ref_clk); chk("masked irq", 32'h0, {31'h0, irq});
    rd(A_IRQ, v, OK); chk("overflow flag", 32'h04, v);
    wr(A_IRQ, 32'h20, OK);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk); chk("irq", 32'h1, {31'h0, irq});
    wr(A_IRQ, 32'h24, OK);
    @(negedge ref_clk); chk("irq cleared", 32'h0, {31'h0, irq});
    rd(A_IRQ, v, OK); chk("flag cleared", 32'h20, v);
    wr(A_IRQ, 32'h0, OK);
    $display("test interrupt done");
    sleep <= 1'b1;
    @(posedge ref_clk);
    rd(A_TICK, v, OK);
    repeat (40) @(posedge ref_clk);
    rd(A_TICK, u, OK); chk("sleep hold", v, u);
    sleep <= 1'b0;
    $display("test sleep done");
    for (int e = 0; e < 2; e++) begin
      wr(A_OPT, (e == 1) ? 32'h38 : 32'h28, OK);
      wr(A_TICK, 32'h0, OK);
      repeat (12) @(posedge ref_clk);
      burst(8'd9);
      rd(A_TICK, v, OK); chk("external edges", 32'h5, v);
    end
    wr(A_OPT, 32'h20, OK);
    wr(A_TICK, 32'h0, OK);
    repeat (12) @(posedge ref_clk);
    burst(8'd16);
    rd(A_TICK, v, OK); chk("divided edges", 32'h4, v);
    $display("test counter done");
    for (int n = 0; n < 8; n++) begin
      wr(A_OPT, n, OK);
      rate(4 << (n + 1), 3 * (4 << (n + 1)), "prescaled rate");
    end
    $display("test prescaler done");
    for (int p = 0; p < 2; p++) begin
      wr(A_OPT, (p == 1) ? 32'h00 : 32'h08, OK);
      repeat (2) @(posedge ref_clk);
      t0 = n_wdt;
      repeat (8) begin
        wdt_source_tick <= 1'b1;
        @(posedge ref_clk);
        wdt_source_tick <= 1'b0;
        repeat (3) @(posedge ref_clk);
      end
      repeat (4) @(posedge ref_clk);
      chk("watchdog ticks", (p == 1) ? 32'h8 : 32'h4, n_wdt - t0);
    end
    $display("test watchdog done");
    finish_test();
  end
endmodule // tick_timer_tb
`default_nettype wire
